/* hw/dual_timer_pkg.sv */
package dual_timer_pkg;

	// ****************************************************************
	// Widths and timing
	// ****************************************************************
	localparam int CNT_W       = 12;
	localparam int CLK_MHZ     = 250;
	localparam int DIV_TIMER   = 4;
	localparam int DIV_C64     = 64;
	localparam int DIV_C8192   = 8192;
	localparam int DIV_C65536  = 65536;
	localparam int PRESC_W     = 16;

	// ****************************************************************
	// Register byte offsets
	// ****************************************************************
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_IRQ_EN  = 8'h04;
	localparam logic [7:0] OFS_A_PRE   = 8'h08;
	localparam logic [7:0] OFS_B_PRE   = 8'h0c;
	localparam logic [7:0] OFS_A_CNT   = 8'h10;
	localparam logic [7:0] OFS_B_CNT   = 8'h14;
	localparam logic [7:0] OFS_STATUS  = 8'h18;

	// ****************************************************************
	// Control fields
	// ****************************************************************
	localparam int CTRL_A_CNT_MODE = 0;
	localparam int CTRL_A_FAST     = 1;
	localparam int CTRL_B_FAST     = 2;
	localparam int CTRL_A_SRC_LO   = 3;
	localparam int CTRL_TONE       = 5;
	localparam int CTRL_A_RUN      = 6;
	localparam int CTRL_B_RUN      = 7;
	localparam int CTRL_W          = 8;

	localparam logic [CTRL_W-1:0] CTRL_RST   = 8'h00;
	localparam logic [CNT_W-1:0]  PRE_RST    = 12'h000;
	localparam logic [CNT_W-1:0]  CNT_MAX    = 12'hfff;
	localparam logic [CNT_W-1:0]  CNT_ZERO   = 12'h000;

	localparam logic [1:0] SRC_DIV64    = 2'h0;
	localparam logic [1:0] SRC_DIV8192  = 2'h1;
	localparam logic [1:0] SRC_DIV65536 = 2'h2;
	localparam logic [1:0] SRC_EXT      = 2'h3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* hw/tick_divider.sv */
`timescale 1ns/100ps
module tick_divider (
	input  wire logic                               clk_sys_i,
	input  wire logic                               resetn_i,
	output logic                                    tick4_o,
	output logic                                    tick64_o,
	output logic                                    tick8192_o,
	output logic                                    tick65536_o
);

	// ****************************************************************
	// Free running prescaler
	// ****************************************************************
	logic [dual_timer_pkg::PRESC_W-1:0] presc_r;

	function automatic logic at_wrap(input logic [dual_timer_pkg::PRESC_W-1:0] v,
		input int div);
		logic [dual_timer_pkg::PRESC_W-1:0] m;
		m = dual_timer_pkg::PRESC_W'(div - 1);
		return (v & m) == m;
	endfunction

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			presc_r     <= '0;
			tick4_o     <= 1'b0;
			tick64_o    <= 1'b0;
			tick8192_o  <= 1'b0;
			tick65536_o <= 1'b0;
		end else begin
			presc_r     <= presc_r + 1'b1;
			tick4_o     <= at_wrap(presc_r, dual_timer_pkg::DIV_TIMER);
			tick64_o    <= at_wrap(presc_r, dual_timer_pkg::DIV_C64);
			tick8192_o  <= at_wrap(presc_r, dual_timer_pkg::DIV_C8192);
			tick65536_o <= at_wrap(presc_r, dual_timer_pkg::DIV_C65536);
		end
	end

endmodule

/* hw/reload_counter.sv */
`timescale 1ns/100ps
module reload_counter #(
	parameter int W = dual_timer_pkg::CNT_W
) (
	input  wire logic                               clk_sys_i,
	input  wire logic                               resetn_i,
	input  wire logic                               step_i,
	input  wire logic                               clear_i,
	input  wire logic [W-1:0]                       preset_i,
	output logic [W-1:0]                            count_o,
	output logic                                    carry_o
);

	// ****************************************************************
	// Up counter with reload on rollover
	// ****************************************************************
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			count_o <= '0;
			carry_o <= 1'b0;
		end else if (clear_i) begin
			count_o <= '0;
			carry_o <= 1'b0;
		end else if (step_i && count_o == {W{1'b1}}) begin
			count_o <= preset_i;
			carry_o <= 1'b1;
		end else begin
			if (step_i) begin
				count_o <= count_o + 1'b1;
			end
			carry_o <= 1'b0;
		end
	end

endmodule

/* hw/dual_timer_tone_unit.sv */
`timescale 1ns/100ps
// Notes on behaviour
// R1: Two 12-bit units; first is timer or counter, second timer only.
// R2: Timer counts up, reloads preset on rollover from all ones.
// R3: Overflow raises that unit's interrupt when its enable bit is set.
// R4: Writing zero to first counter in counter mode restarts it from zero.
// R5: Reading a running count returns it and never disturbs it.
// R6: Timer mode steps at full rate or rate divided by four.
// R7: Counter mode steps at rate over 64, 8192, 65536 or external input.
// R8: Mode select affects only the first unit.
// R9: Dual tone mode toggles each tone output on that unit's overflow.
// R10: Software loads presets to set each tone channel's frequency.
// R11: First unit overflow also drives a non-maskable sample trigger.
// R12: Preset writes wait in a reload register used at next overflow.
module dual_timer_tone_unit (
	input  wire logic                               clk_sys_i,
	input  wire logic                               resetn_i,
	input  wire logic                               ext_count_pin_i,
	input  wire logic [7:0]                         s_axi_awaddr_i,
	input  wire logic                               s_axi_awvalid_i,
	output logic                                    s_axi_awready_o,
	input  wire logic [31:0]                        s_axi_wdata_i,
	input  wire logic [3:0]                         s_axi_wstrb_i,
	input  wire logic                               s_axi_wvalid_i,
	output logic                                    s_axi_wready_o,
	output logic [1:0]                              s_axi_bresp_o,
	output logic                                    s_axi_bvalid_o,
	input  wire logic                               s_axi_bready_i,
	input  wire logic [7:0]                         s_axi_araddr_i,
	input  wire logic                               s_axi_arvalid_i,
	output logic                                    s_axi_arready_o,
	output logic [31:0]                             s_axi_rdata_o,
	output logic [1:0]                              s_axi_rresp_o,
	output logic                                    s_axi_rvalid_o,
	input  wire logic                               s_axi_rready_i,
	output logic                                    timer_a_irq_o,
	output logic                                    timer_b_irq_o,
	output logic                                    timer_a_nmi_o,
	output logic                                    tone_a_o,
	output logic                                    tone_b_o
);

	localparam int W = dual_timer_pkg::CNT_W;

	// ****************************************************************
	// Registers and wires
	// ****************************************************************
	logic [dual_timer_pkg::CTRL_W-1:0] ctrl_r;
	logic [1:0]                        irq_en_r;
	logic [W-1:0]                      a_pre_r;
	logic [W-1:0]                      b_pre_r;
	logic [W-1:0]                      a_cnt;
	logic [W-1:0]                      b_cnt;
	logic                              a_carry;
	logic                              b_carry;
	logic                              a_clear;
	logic                              a_step;
	logic                              b_step;
	logic                              t4;
	logic                              t64;
	logic                              t8192;
	logic                              t65536;
	logic                              ext_d_r;
	logic                              ext_edge;
	logic                              aw_got_r;
	logic                              w_got_r;
	logic [7:0]                        aw_addr_r;
	logic [31:0]                       w_data_r;
	logic [3:0]                        w_strb_r;
	logic                              wr_go;
	logic [31:0]                       rd_val;
	logic                              rd_ok;

	function automatic logic [W-1:0] merge12(input logic [W-1:0] old,
		input logic [31:0] d, input logic [3:0] s);
		logic [W-1:0] r;
		r = old;
		if (s[0]) r[7:0] = d[7:0];
		if (s[1]) r[W-1:8] = d[W-1:8];
		return r;
	endfunction

	// ****************************************************************
	// Clock sources
	// ****************************************************************
	tick_divider u_div (
		.clk_sys_i   (clk_sys_i),
		.resetn_i    (resetn_i),
		.tick4_o     (t4),
		.tick64_o    (t64),
		.tick8192_o  (t8192),
		.tick65536_o (t65536)
	);

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			ext_d_r <= 1'b0;
		end else begin
			ext_d_r <= ext_count_pin_i;
		end
	end
	assign ext_edge = ext_count_pin_i & ~ext_d_r;

	always_comb begin
		if (ctrl_r[dual_timer_pkg::CTRL_A_CNT_MODE]) begin // R8
			unique case (ctrl_r[dual_timer_pkg::CTRL_A_SRC_LO +: 2]) // R7
				dual_timer_pkg::SRC_DIV64:    a_step = t64;
				dual_timer_pkg::SRC_DIV8192:  a_step = t8192;
				dual_timer_pkg::SRC_DIV65536: a_step = t65536;
				default:                      a_step = ext_edge;
			endcase
		end else begin
			a_step = ctrl_r[dual_timer_pkg::CTRL_A_FAST] ? 1'b1 : t4; // R6
		end
		a_step = a_step & ctrl_r[dual_timer_pkg::CTRL_A_RUN];
		b_step = (ctrl_r[dual_timer_pkg::CTRL_B_FAST] ? 1'b1 : t4) // R6
			& ctrl_r[dual_timer_pkg::CTRL_B_RUN];
	end

	// ****************************************************************
	// Counters
	// ****************************************************************
	assign a_clear = wr_go && aw_addr_r == dual_timer_pkg::OFS_A_CNT
		&& ctrl_r[dual_timer_pkg::CTRL_A_CNT_MODE]
		&& merge12(a_cnt, w_data_r, w_strb_r) == dual_timer_pkg::CNT_ZERO; // R4

	reload_counter #(.W(W)) u_cnt_a ( // R1 R2 R12
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.step_i    (a_step),
		.clear_i   (a_clear),
		.preset_i  (a_pre_r),
		.count_o   (a_cnt),
		.carry_o   (a_carry)
	);

	reload_counter #(.W(W)) u_cnt_b ( // R1 R2 R12
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.step_i    (b_step),
		.clear_i   (1'b0),
		.preset_i  (b_pre_r),
		.count_o   (b_cnt),
		.carry_o   (b_carry)
	);

	// ****************************************************************
	// Interrupts and tones
	// ****************************************************************
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			timer_a_irq_o <= 1'b0;
			timer_b_irq_o <= 1'b0;
			timer_a_nmi_o <= 1'b0;
		end else begin
			timer_a_irq_o <= a_carry & irq_en_r[0]; // R3
			timer_b_irq_o <= b_carry & irq_en_r[1]; // R3
			timer_a_nmi_o <= a_carry; // R11
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			tone_a_o <= 1'b0;
			tone_b_o <= 1'b0;
		end else if (!ctrl_r[dual_timer_pkg::CTRL_TONE]) begin
			tone_a_o <= 1'b0;
			tone_b_o <= 1'b0;
		end else begin
			if (a_carry) tone_a_o <= ~tone_a_o; // R9 R10
			if (b_carry) tone_b_o <= ~tone_b_o; // R9 R10
		end
	end

	// ****************************************************************
	// Write channel
	// ****************************************************************
	assign wr_go = aw_got_r && w_got_r && !s_axi_bvalid_o;

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			aw_got_r  <= 1'b0;
			w_got_r   <= 1'b0;
			aw_addr_r <= '0;
			w_data_r  <= '0;
			w_strb_r  <= '0;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_got_r  <= 1'b1;
				aw_addr_r <= s_axi_awaddr_i;
			end else if (wr_go) begin
				aw_got_r <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_got_r  <= 1'b1;
				w_data_r <= s_axi_wdata_i;
				w_strb_r <= s_axi_wstrb_i;
			end else if (wr_go) begin
				w_got_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o  <= 1'b0;
		end else begin
			s_axi_awready_o <= !aw_got_r && !(s_axi_awvalid_i && s_axi_awready_o)
				&& !s_axi_bvalid_o;
			s_axi_wready_o  <= !w_got_r && !(s_axi_wvalid_i && s_axi_wready_o)
				&& !s_axi_bvalid_o;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= dual_timer_pkg::RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid_o <= 1'b1;
			unique case (aw_addr_r)
				dual_timer_pkg::OFS_CTRL, dual_timer_pkg::OFS_IRQ_EN,
				dual_timer_pkg::OFS_A_PRE, dual_timer_pkg::OFS_B_PRE,
				dual_timer_pkg::OFS_A_CNT, dual_timer_pkg::OFS_B_CNT,
				dual_timer_pkg::OFS_STATUS:
					s_axi_bresp_o <= dual_timer_pkg::RESP_OKAY;
				default:
					s_axi_bresp_o <= dual_timer_pkg::RESP_SLVERR;
			endcase
		end else if (s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	// ****************************************************************
	// Software registers
	// ****************************************************************
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			ctrl_r   <= dual_timer_pkg::CTRL_RST;
			irq_en_r <= 2'h0;
			a_pre_r  <= dual_timer_pkg::PRE_RST;
			b_pre_r  <= dual_timer_pkg::PRE_RST;
		end else if (wr_go) begin
			if (aw_addr_r == dual_timer_pkg::OFS_CTRL && w_strb_r[0]) begin
				ctrl_r <= w_data_r[dual_timer_pkg::CTRL_W-1:0];
			end
			if (aw_addr_r == dual_timer_pkg::OFS_IRQ_EN && w_strb_r[0]) begin
				irq_en_r <= w_data_r[1:0];
			end
			if (aw_addr_r == dual_timer_pkg::OFS_A_PRE) begin
				a_pre_r <= merge12(a_pre_r, w_data_r, w_strb_r); // R12
			end
			if (aw_addr_r == dual_timer_pkg::OFS_B_PRE) begin
				b_pre_r <= merge12(b_pre_r, w_data_r, w_strb_r); // R12
			end
		end
	end

	// ****************************************************************
	// Read channel
	// ****************************************************************
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_ok  = 1'b1;
		unique case (s_axi_araddr_i)
			dual_timer_pkg::OFS_CTRL:   rd_val[dual_timer_pkg::CTRL_W-1:0] = ctrl_r;
			dual_timer_pkg::OFS_IRQ_EN: rd_val[1:0] = irq_en_r;
			dual_timer_pkg::OFS_A_PRE:  rd_val[W-1:0] = a_pre_r;
			dual_timer_pkg::OFS_B_PRE:  rd_val[W-1:0] = b_pre_r;
			dual_timer_pkg::OFS_A_CNT:  rd_val[W-1:0] = a_cnt; // R5
			dual_timer_pkg::OFS_B_CNT:  rd_val[W-1:0] = b_cnt; // R5
			dual_timer_pkg::OFS_STATUS: rd_val[1:0] = {tone_b_o, tone_a_o};
			default:                    rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= 32'h0000_0000;
			s_axi_rresp_o   <= dual_timer_pkg::RESP_OKAY;
		end else if (s_axi_rvalid_o) begin
			if (s_axi_rready_i) begin
				s_axi_rvalid_o <= 1'b0;
			end
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b1;
			s_axi_rdata_o   <= rd_val;
			s_axi_rresp_o   <= rd_ok ? dual_timer_pkg::RESP_OKAY
				: dual_timer_pkg::RESP_SLVERR;
		end else begin
			s_axi_arready_o <= 1'b1;
		end
	end

endmodule

/* tb/dual_timer_tone_unit_properties.sv */
`timescale 1ns/100ps
module dual_timer_tone_unit_properties (
	input wire logic        clk_sys_i,
	input wire logic        resetn_i,
	input wire logic        s_axi_awvalid_i,
	input wire logic        s_axi_awready_o,
	input wire logic        s_axi_wvalid_i,
	input wire logic        s_axi_wready_o,
	input wire logic [1:0]  s_axi_bresp_o,
	input wire logic        s_axi_bvalid_o,
	input wire logic        s_axi_bready_i,
	input wire logic        s_axi_arvalid_i,
	input wire logic        s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic [1:0]  s_axi_rresp_o,
	input wire logic        s_axi_rvalid_o,
	input wire logic        s_axi_rready_i,
	input wire logic        timer_a_irq_o,
	input wire logic        timer_a_nmi_o,
	input wire logic        tone_a_o
);
	// ****************************************************************
	// Bus and timer relations
	// ****************************************************************
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	sequence aw_w_taken;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	endsequence
	sequence b_answer;
		##2 s_axi_bvalid_o;
	endsequence
	a_write_answer_time: assert property (aw_w_taken |-> b_answer)
		else $error("write response not two cycles after request");
	a_read_answer_time: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read data not one cycle after request");
	a_bresp_held: assert property (s_axi_bvalid_o && !s_axi_bready_i
		|=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response dropped");
	a_rdata_held: assert property (s_axi_rvalid_o && !s_axi_rready_i
		|=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data dropped");
	a_rdata_width: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:12] == 20'h00000)
		else $error("read data wider than count");
	a_slverr_zero: assert property (s_axi_rvalid_o && s_axi_rresp_o == dual_timer_pkg::RESP_SLVERR
		|-> s_axi_rdata_o == 32'h00000000) else $error("refused read carries data");
	a_irq_with_nmi: assert property (timer_a_irq_o |-> timer_a_nmi_o)
		else $error("interrupt without overflow");
	a_tone_on_wrap: assert property ($rose(tone_a_o) |-> timer_a_nmi_o)
		else $error("tone rose without overflow");
endmodule
bind dual_timer_tone_unit dual_timer_tone_unit_properties props_u (.*);

/* tb/axi_lite_master.sv */
`timescale 1ns/100ps
module axi_lite_master (
	input  wire logic        clk_sys_i,
	output logic [7:0]       awaddr_o,
	output logic             awvalid_o,
	input  wire logic        awready_i,
	output logic [31:0]      wdata_o,
	output logic [3:0]       wstrb_o,
	output logic             wvalid_o,
	input  wire logic        wready_i,
	input  wire logic [1:0]  bresp_i,
	input  wire logic        bvalid_i,
	output logic             bready_o,
	output logic [7:0]       araddr_o,
	output logic             arvalid_o,
	input  wire logic        arready_i,
	input  wire logic [31:0] rdata_i,
	input  wire logic [1:0]  rresp_i,
	input  wire logic        rvalid_i,
	output logic             rready_o
);
	// ****************************************************************
	// Processor side bus cycles
	// ****************************************************************
	initial begin
		{awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
		{araddr_o, arvalid_o, rready_o} = '0;
		wstrb_o = 4'hf;
	end
	// Software loads presets and clears counts with these cycles
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic done;
		awaddr_o <= a;
		wdata_o <= d;
		awvalid_o <= 1'b1;
		wvalid_o <= 1'b1;
		bready_o <= 1'b1;
		do begin
			@(posedge clk_sys_i);
			if (awready_i) begin
				awvalid_o <= 1'b0;
				awaddr_o <= ~a;
			end
			if (wready_i) begin
				wvalid_o <= 1'b0;
				wdata_o <= ~d;
			end
			done = (bvalid_i === 1'b1);
			r = bresp_i;
		end while (!done);
		bready_o <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic done;
		araddr_o <= a;
		arvalid_o <= 1'b1;
		rready_o <= 1'b1;
		do begin
			@(posedge clk_sys_i);
			if (arready_i) begin
				arvalid_o <= 1'b0;
				araddr_o <= ~a;
			end
			done = (rvalid_i === 1'b1);
			d = rdata_i;
			r = rresp_i;
		end while (!done);
		rready_o <= 1'b0;
		@(posedge clk_sys_i);
	endtask
endmodule

/* tb/dual_timer_tone_unit_tb.sv */
`timescale 1ns/100ps
module dual_timer_tone_unit_tb;
	logic        clk_sys_i = 1'b0;
	logic        resetn_i = 1'b0;
	logic        ext_count_pin_i = 1'b0;
	logic        seen_a = 1'b0;
	logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
	logic [31:0] s_axi_wdata_i, s_axi_rdata_o, d;
	logic [3:0]  s_axi_wstrb_i;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, r;
	logic        s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
	logic        s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o;
	logic        s_axi_rvalid_o, s_axi_rready_i, t0;
	logic        timer_a_irq_o, timer_b_irq_o, timer_a_nmi_o, tone_a_o, tone_b_o;
	int          errors = 0;
	int          comparisons = 0;
	int          n, i;
	wire [2:0]   pulses = {timer_b_irq_o, timer_a_irq_o, timer_a_nmi_o};

	dual_timer_tone_unit dut_u (.*);
	axi_lite_master master_u (.clk_sys_i, .awaddr_o(s_axi_awaddr_i), .awvalid_o(s_axi_awvalid_i),
		.awready_i(s_axi_awready_o), .wdata_o(s_axi_wdata_i), .wstrb_o(s_axi_wstrb_i),
		.wvalid_o(s_axi_wvalid_i), .wready_i(s_axi_wready_o), .bresp_i(s_axi_bresp_o),
		.bvalid_i(s_axi_bvalid_o), .bready_o(s_axi_bready_i), .araddr_o(s_axi_araddr_i),
		.arvalid_o(s_axi_arvalid_i), .arready_i(s_axi_arready_o), .rdata_i(s_axi_rdata_o),
		.rresp_i(s_axi_rresp_o), .rvalid_i(s_axi_rvalid_o), .rready_o(s_axi_rready_i));

	// ****************************************************************
	// Helpers
	// ****************************************************************
	initial forever #2 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) if (timer_a_irq_o === 1'b1) seen_a <= 1'b1;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		master_u.wr(a, v, r);
		chk({30'h0, r}, {30'h0, dual_timer_pkg::RESP_OKAY});
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		master_u.rd(a, d, r);
		chk(d, exp);
		chk({30'h0, r}, {30'h0, dual_timer_pkg::RESP_OKAY});
	endtask
	task automatic gap(input int k, output int p);
		for (int j = 0; j < 20000 && pulses[k] !== 1'b1; j++) @(posedge clk_sys_i);
		@(posedge clk_sys_i);
		p = 1;
		while (pulses[k] !== 1'b1 && p < 20000) begin
			@(posedge clk_sys_i);
			p++;
		end
	endtask
	task automatic ext_pulses(input int cnt);
		repeat (cnt) begin
			ext_count_pin_i <= 1'b1;
			repeat (4) @(posedge clk_sys_i);
			ext_count_pin_i <= 1'b0;
			repeat (4) @(posedge clk_sys_i);
		end
	endtask
	task automatic end_sim;
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#200000;
		errors++;
		end_sim;
	end

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		repeat (12) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		for (i = 0; i < 7; i++) rchk(8'(i * 4), 32'h0);
		master_u.rd(8'h1c, d, r);
		chk(d, 32'h0);
		chk({30'h0, r}, {30'h0, dual_timer_pkg::RESP_SLVERR});
		master_u.wr(8'h1c, 32'h1, r);
		chk({30'h0, r}, {30'h0, dual_timer_pkg::RESP_SLVERR});
		wr(dual_timer_pkg::OFS_B_CNT, 32'h5);
		rchk(dual_timer_pkg::OFS_B_CNT, 32'h0);
		wr(dual_timer_pkg::OFS_CTRL, 32'h59);
		ext_pulses(5);
		rchk(dual_timer_pkg::OFS_A_CNT, 32'h5);
		rchk(dual_timer_pkg::OFS_A_CNT, 32'h5);
		wr(dual_timer_pkg::OFS_A_CNT, 32'h0);
		rchk(dual_timer_pkg::OFS_A_CNT, 32'h0);
		ext_pulses(3);
		rchk(dual_timer_pkg::OFS_A_CNT, 32'h3);
		wr(dual_timer_pkg::OFS_CTRL, 32'h41);
		wr(dual_timer_pkg::OFS_A_CNT, 32'h0);
		repeat (640) @(posedge clk_sys_i);
		master_u.rd(dual_timer_pkg::OFS_A_CNT, d, r);
		chk(32'(d >= 32'd9 && d <= 32'd11), 32'h1);
		wr(dual_timer_pkg::OFS_A_PRE, 32'hffe);
		wr(dual_timer_pkg::OFS_CTRL, 32'h42);
		gap(0, n);
		chk(32'(n), 32'd2);
		wr(dual_timer_pkg::OFS_A_PRE, 32'hffc);
		gap(0, n);
		gap(0, n);
		chk(32'(n), 32'd4);
		wr(dual_timer_pkg::OFS_CTRL, 32'h40);
		gap(0, n);
		gap(0, n);
		chk(32'(n), 32'd16);
		chk({31'h0, seen_a}, 32'h0);
		wr(dual_timer_pkg::OFS_IRQ_EN, 32'h3);
		gap(1, n);
		chk(32'(n), 32'd16);
		wr(dual_timer_pkg::OFS_B_PRE, 32'hffc);
		wr(dual_timer_pkg::OFS_CTRL, 32'h85);
		gap(2, n);
		chk(32'(n), 32'd4);
		wr(dual_timer_pkg::OFS_CTRL, 32'he6);
		gap(2, n);
		t0 = tone_b_o;
		gap(2, n);
		chk({31'h0, tone_b_o}, {31'h0, ~t0});
		gap(0, n);
		t0 = tone_a_o;
		gap(0, n);
		chk({31'h0, tone_a_o}, {31'h0, ~t0});
		wr(dual_timer_pkg::OFS_CTRL, 32'h0);
		repeat (2) @(posedge clk_sys_i);
		chk({30'h0, tone_a_o, tone_b_o}, 32'h0);
		end_sim;
	end
endmodule
